// File: design/atwrc_params.svh
/*
 * Constants of the two-wire converter readout control: timing counts,
 * frame positions and filter sizing.
 * Assumes a 50 MHz system clock; included by its bare name.
 */
// Functional notes
// - Digital power-on reset always runs a self-calibration before any results.
// - Internal oscillator, 2.4576 or 2.2528 MHz, divided down for timing.
// - Fourth_order_sinc_filter filter cleared after each conversion in single mode only.
// - Output rate fixed per variant: 120 sps fast, 13.75 sps slow.
// - Ready/data idles high, goes low with new result until clocked.
// - Each of the first 16 serial clock rising edges presents the next result bit.
// - Result is 16-bit two's complement, shifted most significant bit first.
// - Last data bit holds; a 25th pulse returns the line high.
// - Unread result is overwritten by the next conversion.
// - Falling edge of a 26th pulse starts a self-calibration.
// - End of commanded calibration is shown by ready falling.
// - Serial clock held high after ready low puts device to sleep.
// - Entering sleep drives ready/data high.
// - Serial clock low in sleep wakes, converts, then signals ready.
// - 26th pulse held high sleeps; on wake calibrate, then signal ready.
// - Active external clock stops the internal oscillator and takes over.
`ifndef ATWRC_PARAMS_SVH
`define ATWRC_PARAMS_SVH

`define ATWRC_SYS_MHZ        50
`define ATWRC_OSC_FAST_HZ    2457600
`define ATWRC_OSC_SLOW_HZ    2252800
// Output rates in milli-samples per second
`define ATWRC_RATE_FAST_MSPS 120000
`define ATWRC_RATE_SLOW_MSPS 13750
`define ATWRC_CONV_CYC_FAST  int'(64'd50000000000 / 64'd120000)
`define ATWRC_CONV_CYC_SLOW  int'(64'd50000000000 / 64'd13750)
`define ATWRC_OSC_CONV_FAST  int'(64'd2457600000 / 64'd120000)
`define ATWRC_OSC_CONV_SLOW  int'(64'd2252800000 / 64'd13750)
`define ATWRC_DECIM          64
`define ATWRC_DATA_BITS      16
`define ATWRC_IDLE_PULSE     25
`define ATWRC_CAL_PULSE      26
`define ATWRC_SLEEP_HOLD_NS  50000
`define ATWRC_SLEEP_HOLD_CYC \
    ((`ATWRC_SLEEP_HOLD_NS * `ATWRC_SYS_MHZ + 999) / 1000)
`define ATWRC_EXT_TO_NS      2000
`define ATWRC_EXT_TO_CYC     ((`ATWRC_EXT_TO_NS * `ATWRC_SYS_MHZ) / 1000)

`endif

// File: design/atwrc_pkg.sv
/*
 * Types of the two-wire converter readout control.
 * Assumes nothing; used by scoped name only.
 */
package atwrc_pkg;

    typedef enum logic [1:0] {
        ST_CAL,
        ST_RUN,
        ST_SLEEP
    } atwrc_state_e;

    // Filtered pin level with its one-cycle edge pulses
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } atwrc_link_s;

endpackage

// File: design/atwrc_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter and edge pulses.
 * Assumes an asynchronous pin; output is on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module atwrc_sync #(
    parameter bit INIT = 1'b0
) (
    // System
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    // Pin and result
    input  wire logic                  pin,
    output var  atwrc_pkg::atwrc_link_s link
);

    logic [2:0] sh;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sh <= {3{INIT}};
        end else begin
            sh <= {sh[1:0], pin};
        end
    end

    // A change counts only once the second and third stages agree
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            link <= '{level: INIT, rise: 1'b0, fall: 1'b0};
        end else if (sh[1] == sh[2] && sh[2] != link.level) begin
            link <= '{level: sh[2], rise: sh[2], fall: !sh[2]};
        end else begin
            link.rise <= 1'b0;
            link.fall <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: design/atwrc_ctrl.sv
/*
 * Control and serial readout of a two-wire delta-sigma converter:
 * conversion timebase, fourth_order_sinc_filter decimation, ready/data framing, calibration
 * and sleep. Assumes sclk and ext_clk are asynchronous pins, mod_bit comes
 * from the modulator on sys_clk, and arst_n is the digital power-on reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "atwrc_params.svh"

module atwrc_ctrl #(
    parameter bit FAST_VARIANT = 1'b1,
    parameter int CONV_CYCLES  = FAST_VARIANT ? `ATWRC_CONV_CYC_FAST
                                              : `ATWRC_CONV_CYC_SLOW,
    parameter int OSC_PER_CONV = FAST_VARIANT ? `ATWRC_OSC_CONV_FAST
                                              : `ATWRC_OSC_CONV_SLOW,
    parameter int DECIM        = `ATWRC_DECIM
) (
    // System
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // Two-wire link
    input  wire logic sclk,
    output var  logic rdy_dout,
    // Clock source
    input  wire logic ext_clk,
    output var  logic osc_en,
    // Modulator stream
    input  wire logic mod_bit,
    // Status
    output var  logic sleeping,
    output var  logic cal_busy
);

    // ------------------------------------------------------------------
    // Sizing
    // ------------------------------------------------------------------
    localparam int DB       = `ATWRC_DATA_BITS;
    localparam int LD       = $clog2(DECIM);
    localparam int IW       = 4 * LD + 2;
    localparam int TICK_CYC = CONV_CYCLES / DECIM;
    localparam int OSC_DIV  = OSC_PER_CONV / DECIM;
    localparam int HOLD     = `ATWRC_SLEEP_HOLD_CYC;
    localparam int EXT_TO   = `ATWRC_EXT_TO_CYC;
    localparam int TW       = $clog2(TICK_CYC);
    localparam int OW       = $clog2(OSC_DIV);
    localparam int HW       = $clog2(HOLD + 1);
    localparam int EW       = $clog2(EXT_TO + 1);
    localparam logic [4:0] IDLE_P = 5'(`ATWRC_IDLE_PULSE);
    localparam logic [4:0] CAL_P  = 5'(`ATWRC_CAL_PULSE);

    if (DECIM < 2 || (DECIM & (DECIM - 1)) != 0 || 4 * LD + 1 < DB ||
        TICK_CYC < 2 || OSC_DIV < 2) begin : g_bad_param
        $error("atwrc_ctrl: unusable decimation or timebase parameters");
    end

    atwrc_pkg::atwrc_link_s  sclk_l;
    atwrc_pkg::atwrc_link_s  ext_l;
    atwrc_pkg::atwrc_state_e state;

    logic [TW-1:0]        int_div;
    logic [OW-1:0]        ext_div;
    logic [EW-1:0]        ext_to;
    logic                 ext_active;
    logic [LD-1:0]        dec_cnt;
    logic                 tick;
    logic                 conv_end;
    logic signed [IW-1:0] integ [4];
    logic signed [IW-1:0] dly   [4];
    logic signed [IW-1:0] comb  [5];
    logic [DB-1:0]        result;
    logic [DB-1:0]        data_q;
    logic [4:0]           pulse_cnt;
    logic                 frame_open;
    logic [HW-1:0]        hold_cnt;
    logic                 single_mode;
    logic                 cal_wake;
    logic                 first_done;
    logic                 sleep_go;
    logic                 cal_go;
    logic                 cal_end;
    logic                 wake;
    logic                 accept;

    atwrc_sync #(.INIT(1'b0)) u_sclk_sync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pin     (sclk),
        .link    (sclk_l)
    );

    atwrc_sync #(.INIT(1'b0)) u_ext_sync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pin     (ext_clk),
        .link    (ext_l)
    );

    // ------------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------------
    // Internal divider stands in for the trimmed oscillator; an external
    // clock counts its own edges instead, so the rate follows that clock.
    assign tick = ext_active ? (ext_l.rise && ext_div == OW'(OSC_DIV - 1))
                             : (int_div == TW'(TICK_CYC - 1));
    assign conv_end = tick && dec_cnt == LD'(DECIM - 1);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_to     <= '0;
            ext_active <= 1'b0;
            osc_en     <= 1'b1;
        end else begin
            ext_to     <= ext_l.rise ? EW'(EXT_TO)
                        : (ext_to != '0 ? ext_to - 1'b1 : ext_to);
            ext_active <= ext_to != '0;
            osc_en     <= !ext_active;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            int_div <= '0;
            ext_div <= '0;
            dec_cnt <= '0;
        end else if (state == atwrc_pkg::ST_SLEEP) begin
            int_div <= '0;
            ext_div <= '0;
            dec_cnt <= '0;
        end else begin
            int_div <= (int_div == TW'(TICK_CYC - 1)) ? '0 : int_div + 1'b1;
            if (ext_l.rise) begin
                ext_div <= (ext_div == OW'(OSC_DIV - 1)) ? '0
                                                         : ext_div + 1'b1;
            end
            if (tick) begin
                dec_cnt <= dec_cnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Fourth_order_sinc_filter decimator
    // ------------------------------------------------------------------
    // Full scale of +2^(4*LD) wraps; accepted, the modulator never holds
    // one level for a whole conversion window.
    always_comb begin
        comb[0] = integ[3];
        for (int k = 0; k < 4; k++) begin
            comb[k+1] = comb[k] - dly[k];
        end
    end
    assign result = comb[4][4*LD -: DB];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int k = 0; k < 4; k++) begin
                integ[k] <= '0;
                dly[k]   <= '0;
            end
        end else if (state == atwrc_pkg::ST_SLEEP ||
                     (conv_end && single_mode)) begin
            for (int k = 0; k < 4; k++) begin
                integ[k] <= '0;
                dly[k]   <= '0;
            end
        end else if (tick) begin
            integ[0] <= integ[0] + (mod_bit ? IW'(1) : -IW'(1));
            for (int k = 1; k < 4; k++) begin
                integ[k] <= integ[k] + integ[k-1];
            end
            if (conv_end) begin
                for (int k = 0; k < 4; k++) begin
                    dly[k] <= comb[k];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode control
    // ------------------------------------------------------------------
    assign sleep_go = state == atwrc_pkg::ST_RUN && frame_open &&
                      sclk_l.level && hold_cnt == HW'(HOLD - 1);
    assign cal_go   = state == atwrc_pkg::ST_RUN && sclk_l.fall &&
                      pulse_cnt == CAL_P;
    assign wake     = state == atwrc_pkg::ST_SLEEP && sclk_l.fall;
    assign cal_end  = state == atwrc_pkg::ST_CAL && conv_end;
    assign accept   = state == atwrc_pkg::ST_RUN && conv_end &&
                      !sleep_go && !cal_go &&
                      (pulse_cnt == '0 || pulse_cnt == IDLE_P);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_cnt <= '0;
        end else if (!sclk_l.level) begin
            hold_cnt <= '0;
        end else if (hold_cnt != HW'(HOLD)) begin
            hold_cnt <= hold_cnt + 1'b1;
        end
    end

    // Power-on reset lands in calibration; the first conversion window is
    // spent calibrating, so no result can precede it.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state       <= atwrc_pkg::ST_CAL;
            cal_busy    <= 1'b1;
            sleeping    <= 1'b0;
            single_mode <= 1'b0;
            cal_wake    <= 1'b0;
            first_done  <= 1'b0;
        end else begin
            unique case (state)
                atwrc_pkg::ST_CAL: begin
                    if (cal_end) begin
                        state      <= atwrc_pkg::ST_RUN;
                        cal_busy   <= 1'b0;
                        first_done <= 1'b1;
                    end
                end
                atwrc_pkg::ST_RUN: begin
                    if (sleep_go) begin
                        state       <= atwrc_pkg::ST_SLEEP;
                        sleeping    <= 1'b1;
                        single_mode <= 1'b1;
                        cal_wake    <= pulse_cnt == CAL_P;
                    end else if (cal_go) begin
                        state    <= atwrc_pkg::ST_CAL;
                        cal_busy <= 1'b1;
                    end
                end
                atwrc_pkg::ST_SLEEP: begin
                    if (wake) begin
                        state    <= cal_wake ? atwrc_pkg::ST_CAL
                                             : atwrc_pkg::ST_RUN;
                        cal_busy <= cal_wake;
                        sleeping <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Ready/data framing
    // ------------------------------------------------------------------
    // A result arriving mid-read is discarded; the next one overwrites an unread
    // result. A rising edge in the accept cycle is dropped.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdy_dout   <= 1'b1;
            pulse_cnt  <= '0;
            frame_open <= 1'b0;
            data_q     <= '0;
        end else if (state != atwrc_pkg::ST_RUN || sleep_go || cal_go) begin
            rdy_dout   <= 1'b1;
            pulse_cnt  <= '0;
            frame_open <= 1'b0;
        end else if (accept) begin
            data_q     <= result;
            rdy_dout   <= 1'b0;
            pulse_cnt  <= '0;
            frame_open <= 1'b1;
        end else if (sclk_l.rise && frame_open && pulse_cnt != CAL_P) begin
            pulse_cnt <= pulse_cnt + 1'b1;
            if (pulse_cnt < 5'(DB)) begin
                rdy_dout <= data_q[4'(DB - 1) - pulse_cnt[3:0]];
            end else if (pulse_cnt == IDLE_P - 5'h01) begin
                rdy_dout <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_por_cal;
        @(posedge sys_clk) disable iff (!arst_n)
        !first_done |-> rdy_dout && state != atwrc_pkg::ST_SLEEP;
    endproperty
    a_por_cal: assert property (p_por_cal)
        else $error("result offered before power-on calibration ended");

    property p_ready_low;
        @(posedge sys_clk) disable iff (!arst_n)
        accept |=> !rdy_dout && frame_open && pulse_cnt == '0;
    endproperty
    a_ready_low: assert property (p_ready_low)
        else $error("ready not low after accepted result");

    property p_shift_bit;
        @(posedge sys_clk) disable iff (!arst_n)
        (state == atwrc_pkg::ST_RUN && !sleep_go && !cal_go && !accept &&
         sclk_l.rise && frame_open && pulse_cnt < 5'(DB))
        |=> rdy_dout == data_q[4'(DB - 1) - $past(pulse_cnt[3:0])];
    endproperty
    a_shift_bit: assert property (p_shift_bit)
        else $error("wrong data bit on ready/data");

    property p_idle_pulse;
        @(posedge sys_clk) disable iff (!arst_n)
        (state == atwrc_pkg::ST_RUN && !accept && sclk_l.rise &&
         frame_open && pulse_cnt == IDLE_P - 5'h01)
        |=> rdy_dout && pulse_cnt == IDLE_P;
    endproperty
    a_idle_pulse: assert property (p_idle_pulse)
        else $error("25th pulse did not return line high");

    property p_cal_26;
        @(posedge sys_clk) disable iff (!arst_n)
        cal_go |=> state == atwrc_pkg::ST_CAL && cal_busy && rdy_dout;
    endproperty
    a_cal_26: assert property (p_cal_26)
        else $error("26th falling edge did not start calibration");

    property p_sleep_high;
        @(posedge sys_clk) disable iff (!arst_n)
        (state == atwrc_pkg::ST_SLEEP && $past(state) != atwrc_pkg::ST_SLEEP)
        |-> rdy_dout && sleeping;
    endproperty
    a_sleep_high: assert property (p_sleep_high)
        else $error("sleep entered with ready/data low");

    property p_hold_sleep;
        @(posedge sys_clk) disable iff (!arst_n)
        (state == atwrc_pkg::ST_RUN && frame_open && sclk_l.level &&
         hold_cnt == HW'(HOLD - 1))
        |=> state == atwrc_pkg::ST_SLEEP && sleeping && rdy_dout;
    endproperty
    a_hold_sleep: assert property (p_hold_sleep)
        else $error("held serial clock did not cause sleep");

    property p_wake;
        @(posedge sys_clk) disable iff (!arst_n)
        wake |=> state == ($past(cal_wake) ? atwrc_pkg::ST_CAL
                                           : atwrc_pkg::ST_RUN);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake went to the wrong mode");

    property p_ext_osc;
        @(posedge sys_clk) disable iff (!arst_n)
        ext_l.rise |-> ##3 !osc_en;
    endproperty
    a_ext_osc: assert property (p_ext_osc)
        else $error("oscillator left on under external clock");

    property p_single_clear;
        @(posedge sys_clk) disable iff (!arst_n)
        (conv_end && single_mode) |=> integ[3] == '0 && dly[0] == '0;
    endproperty
    a_single_clear: assert property (p_single_clear)
        else $error("filter not cleared in single mode");

endmodule

`default_nettype wire

// File: testbench/atwrc_host_model.sv
/*
 * Host model for the two-wire readout link: drives the serial clock
 * at a 160 ns period and samples ready/data between pulses.
 * Assumes a 50 MHz sys_clk; all changes land on its falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module atwrc_host_model (
    // System
    input  wire logic sys_clk,
    // Link
    input  wire logic rdy_dout,
    output var  logic sclk
);
    initial sclk = 1'b0;

    // ----------------------------------------------------------------
    // Link timing
    // ----------------------------------------------------------------
    task automatic half();
        repeat (4) @(negedge sys_clk);
    endtask

    // Sample at the end of the low phase, well after the line settles
    task automatic pulses(input int n, output logic [25:0] seen,
                          output bit ok);
        int w;
        seen = '0;
        w = 0;
        while (rdy_dout !== 1'b0 && w < 5000) begin
            @(negedge sys_clk);
            w++;
        end
        ok = (w < 5000);
        @(negedge sys_clk);
        for (int i = 0; i < n && ok; i++) begin
            sclk = 1'b1;
            half();
            sclk = 1'b0;
            half();
            seen[i] = rdy_dout;
        end
    endtask

    // Clock parked high long enough to count as a sleep request
    task automatic hold_high(input int cyc);
        sclk = 1'b1;
        repeat (cyc) @(negedge sys_clk);
    endtask

    task automatic drop();
        sclk = 1'b0;
    endtask
endmodule

`default_nettype wire

// File: testbench/tb_top.sv
/*
 * Self-checking bench of the readout control with a host model.
 * Assumes shortened conversion windows of 640 cycles and a zero stream.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int CONV = 640;
    logic sys_clk, arst_n, sclk, ext_clk, mod_bit;
    logic rdy_dout, osc_en, sleeping, cal_busy;
    int   err_total, n_checks;
    logic [25:0] seen;
    bit   ok;

    atwrc_ctrl #(.CONV_CYCLES(CONV), .OSC_PER_CONV(640), .DECIM(64)) dut_u (
        .sys_clk(sys_clk), .arst_n(arst_n), .sclk(sclk),
        .rdy_dout(rdy_dout), .ext_clk(ext_clk), .osc_en(osc_en),
        .mod_bit(mod_bit), .sleeping(sleeping), .cal_busy(cal_busy)
    );

    atwrc_host_model host_u (
        .sys_clk(sys_clk), .rdy_dout(rdy_dout), .sclk(sclk)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [25:0] exp,
                       input logic [25:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    function automatic logic sig(input int s);
        case (s)
            0: return rdy_dout;
            1: return cal_busy;
            2: return sleeping;
            default: return osc_en;
        endcase
    endfunction

    // Bounded wait; a run-out is a mismatch and ends the run
    task automatic wait_for(input int s, input logic want, input int lim,
                            output int n);
        n = 0;
        while (sig(s) !== want && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        n_checks++;
        if (n >= lim) begin
            err_total++;
            $display("MISMATCH wait sel %0d expected %0b seen timeout",
                     s, want);
            close_out();
        end
    endtask

    task automatic read(input int n);
        host_u.pulses(n, seen, ok);
        if (!ok) begin
            err_total++;
            $display("MISMATCH ready expected 0 seen timeout");
            close_out();
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_startup();
        int n;
        chk("cal in reset", 26'h1, {25'h0, cal_busy});
        chk("rdy in reset", 26'h1, {25'h0, rdy_dout});
        arst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("cal after por", 26'h1, {25'h0, cal_busy});
        wait_for(0, 1'b0, 4 * CONV, n);
        chk("cal done", 26'h0, {25'h0, cal_busy});
        repeat (100) @(negedge sys_clk);
        chk("rdy stays low", 26'h0, {25'h0, rdy_dout});
        $display("test startup done");
    endtask

    task automatic t_read_rate();
        logic [15:0] data;
        int n;
        repeat (6 * CONV) @(negedge sys_clk);
        read(25);
        for (int i = 0; i < 16; i++)
            data[15 - i] = seen[i];
        chk("data", 26'h8000, {10'h0, data});
        chk("hold bits", {18'h0, {8{data[0]}}}, {18'h0, seen[23:16]});
        chk("pulse 25", 26'h1, {25'h0, seen[24]});
        wait_for(0, 1'b0, 2 * CONV, n);
        read(25);
        wait_for(0, 1'b0, 2 * CONV, n);
        chk("rate", 26'h1, {25'h0, (201 + n) > (CONV - 9)
                            && (201 + n) < (CONV + 9)});
        $display("test read_rate done");
    endtask

    task automatic t_cal_cmd();
        int n;
        read(26);
        wait_for(1, 1'b1, 20, n);
        chk("rdy in cal", 26'h1, {25'h0, rdy_dout});
        wait_for(0, 1'b0, 4 * CONV, n);
        chk("cal over", 26'h0, {25'h0, cal_busy});
        $display("test cal_cmd done");
    endtask

    task automatic t_sleep(input int npulse, input logic cal_exp);
        int n;
        read(npulse);
        host_u.hold_high(2600);
        chk("sleeping", 26'h1, {25'h0, sleeping});
        chk("rdy asleep", 26'h1, {25'h0, rdy_dout});
        host_u.drop();
        wait_for(2, 1'b0, 20, n);
        repeat (4) @(negedge sys_clk);
        chk("cal on wake", {25'h0, cal_exp}, {25'h0, cal_busy});
        wait_for(0, 1'b0, 4 * CONV, n);
        chk("cal after wake", 26'h0, {25'h0, cal_busy});
        $display("test sleep %0d done", npulse);
    endtask

    task automatic t_ext_clk();
        int n;
        for (int i = 0; i < 20; i++) begin
            repeat (2) @(negedge sys_clk);
            ext_clk = ~ext_clk;
        end
        chk("osc off", 26'h0, {25'h0, osc_en});
        wait_for(3, 1'b1, 300, n);
        $display("test ext_clk done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        err_total = 0;
        n_checks = 0;
        arst_n = 1'b0;
        ext_clk = 1'b0;
        mod_bit = 1'b0;
        repeat (20) @(negedge sys_clk);
        t_startup();
        t_read_rate();
        t_cal_cmd();
        t_sleep(5, 1'b0);
        t_sleep(25, 1'b1);
        t_ext_clk();
        close_out();
    end
endmodule

`default_nettype wire
